// ===== io_register_space_bit_access_test.sv
`timescale 1ns/1ns
module io_register_space_bit_access_test;
  import iorb_pkg::*;
  logic       i_clk;
  logic       i_nrst;
  logic       ce;
  iorb_req_t  req;
  iorb_rsp_t  rsp;
  iorb_rsp_t  r;
  iorb_bank_t hw_set;
  iorb_bank_t hw_val;
  iorb_bank_t regs;
  int         err_total = 0;
  int         n_compared = 0;
  int         cyc = 0;
  logic [7:0] ex_set [5] = '{8'h01, 8'h03, 8'h07, 8'h0F, 8'h0F};
  // Enable is driven so that the freeze can be exercised
  iorb_bank DUT (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(ce), .i_req(req),
    .i_hw_set(hw_set), .i_hw_val(hw_val), .o_rsp(rsp), .o_regs(regs));
  iorb_core_model u_core (.i_clk(i_clk), .i_rsp(rsp), .o_req(req));
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic acc(iorb_op_t o, logic ds, logic [7:0] a, logic [2:0] b, logic [7:0] d);
    u_core.access(o, ds, a, b, d, r);
  endtask
  // A hang ends the run as a failure
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      err_total++;
      conclude();
    end
  end
  initial begin
    i_nrst = 1'b0;
    ce     = 1'b1;
    hw_set = '0;
    hw_val = '0;
    repeat (10) @(posedge i_clk);
    i_nrst <= 1'b1;
    @(posedge i_clk);
    for (int i = 0; i < 25; i++)
      chk("reset", 8'h00, regs[i]);
    $display("reset test done");
    // Walk set up the latch; bit 4 is reserved and stays clear
    for (int i = 0; i < 5; i++) begin
      acc(IORB_OP_SINGLE_BIT_SET, 1'b0, 8'h18, 3'(i), 8'h00);
      chk("latch set", ex_set[i], regs[24]);
    end
    acc(IORB_OP_SINGLE_BIT_CLEAR, 1'b0, 8'h18, 3'h2, 8'h00);
    chk("latch clear", 8'h0B, regs[24]);
    $display("bit set clear test done");
    // Pin levels 0x05 give alternating skips; latch 0x0B skips on clear bit 2 only
    hw_val[22] <= 8'h05;
    for (int i = 0; i < 4; i++) begin
      acc(IORB_OP_SKIP_IF_BIT_SET, 1'b0, 8'h16, 3'(i), 8'h00);
      chk("skip set", {7'h00, ~i[0]}, {7'h00, r.skip});
      chk("skip bit", {7'h00, ~i[0]}, {7'h00, r.bit_val});
      acc(IORB_OP_SKIP_IF_BIT_CLEAR, 1'b0, 8'h18, 3'(i), 8'h00);
      chk("skip clear", {7'h00, i == 2}, {7'h00, r.skip});
    end
    $display("skip test done");
    // Pending flags must survive bit ops elsewhere and zero writes
    hw_set[11] <= 8'h27;
    hw_set[6] <= 8'h10;
    @(posedge i_clk);
    hw_set <= '0;
    acc(IORB_OP_SINGLE_BIT_SET, 1'b0, 8'h06, 3'h7, 8'h00);
    chk("status bit set", 8'h90, regs[6]);
    acc(IORB_OP_SINGLE_BIT_SET, 1'b0, 8'h0B, 3'h0, 8'h00);
    chk("flag bit set", 8'h26, regs[11]);
    acc(IORB_OP_WRITE, 1'b0, 8'h0B, 3'h0, 8'h00);
    chk("flag zero write", 8'h26, regs[11]);
    acc(IORB_OP_WRITE, 1'b0, 8'h0B, 3'h0, 8'h04);
    chk("flag one write", 8'h22, regs[11]);
    $display("flag test done");
    // Low enable holds a pending flag pulse back; then set must beat clear
    ce <= 1'b0;
    hw_set[11] <= 8'h04;
    repeat (2) @(posedge i_clk);
    chk("frozen flag", 8'h22, regs[11]);
    ce <= 1'b1;
    acc(IORB_OP_WRITE, 1'b0, 8'h0B, 3'h0, 8'h04);
    chk("set beats clear", 8'h26, regs[11]);
    hw_set <= '0;
    $display("freeze test done");
    // Bit ops above the low range or through the alias, and reads of reserved locations, are refused
    acc(IORB_OP_SINGLE_BIT_SET, 1'b0, 8'h20, 3'h0, 8'h00);
    chk("high bit op", 8'h01, {7'h00, r.err});
    chk("high bit ack", 8'h01, {7'h00, r.ack});
    acc(IORB_OP_SINGLE_BIT_SET, 1'b1, 8'h38, 3'h2, 8'h00);
    chk("alias bit op", 8'h0B, regs[24]);
    chk("alias bit err", 8'h01, {7'h00, r.err});
    acc(IORB_OP_READ, 1'b0, 8'h09, 3'h0, 8'h00);
    chk("reserved read err", 8'h01, {7'h00, r.err});
    chk("reserved read data", 8'h00, r.rdata);
    $display("refusal test done");
    // Both spaces reach the same scratch storage
    acc(IORB_OP_WRITE, 1'b1, 8'h33, 3'h0, 8'hA5);
    acc(IORB_OP_READ, 1'b0, 8'h13, 3'h0, 8'h00);
    chk("alias write", 8'hA5, r.rdata);
    acc(IORB_OP_WRITE, 1'b0, 8'h15, 3'h0, 8'h3C);
    acc(IORB_OP_READ, 1'b1, 8'h35, 3'h0, 8'h00);
    chk("alias read", 8'h3C, r.rdata);
    chk("alias hit", 8'h01, {7'h00, r.hit});
    $display("alias test done");
    conclude();
  end
endmodule // io_register_space_bit_access_test

// ===== iorb_bank.sv
`timescale 1ns/1ns
module iorb_bank
  import iorb_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  input  wire logic       i_ce,
  input  wire iorb_req_t  i_req,
  input  wire iorb_bank_t i_hw_set,
  input  wire iorb_bank_t i_hw_val,
  output iorb_rsp_t       o_rsp,
  output iorb_bank_t      o_regs
);

  // Response state; register contents are held in the cells
  typedef struct packed {
    iorb_rsp_t rsp;
  } iorb_bank_st_t;

  iorb_bank_st_t         st_r;
  iorb_bank_st_t         st_nxt;
  iorb_bank_t            rd_bank;
  logic [IORB_IOW-1:0]   io_addr;
  logic                  in_space;
  logic                  mapped;
  logic                  is_write;
  logic                  is_bit_wr;
  logic                  is_bit_test;
  logic                  bit_ok;
  logic                  accept;
  logic                  do_wr;
  logic [IORB_DW-1:0]    wmask;
  logic [IORB_DW-1:0]    wdata;
  logic [IORB_DW-1:0]    rd_sel;
  logic [IORB_AW-1:0]    ds_diff;

  // Operation classes
  assign is_write    = (i_req.op == IORB_OP_WRITE);
  assign is_bit_wr   = (i_req.op == IORB_OP_SINGLE_BIT_SET) ||
                       (i_req.op == IORB_OP_SINGLE_BIT_CLEAR);
  assign is_bit_test = (i_req.op == IORB_OP_SKIP_IF_BIT_SET) ||
                       (i_req.op == IORB_OP_SKIP_IF_BIT_CLEAR);

  // Both address paths fold onto one I/O index, so one storage serves both
  always_comb begin
    ds_diff  = i_req.addr - IORB_DS_OFS;
    in_space = 1'b0;
    io_addr  = '0;
    if (i_req.data_space) begin
      in_space = (i_req.addr >= IORB_DS_OFS) && (i_req.addr <= IORB_DS_LAST);
      io_addr  = ds_diff[IORB_IOW-1:0];
    end else begin
      in_space = (i_req.addr <= IORB_IO_TOP);
      io_addr  = i_req.addr[IORB_IOW-1:0];
    end
  end

  // A location is mapped when any of its bits is implemented
  always_comb begin
    mapped = 1'b0;
    if (in_space && (io_addr <= IORB_IO_LAST)) begin
      mapped = |(IORB_RW_MASK[io_addr[4:0]] | IORB_W1C_MASK[io_addr[4:0]] |
                 IORB_HW_MASK[io_addr[4:0]]);
    end
  end

  // Bit operations only come through the I/O path and the low range
  assign bit_ok = !i_req.data_space && in_space && (io_addr <= IORB_BIT_MAX);

  // Writes to reserved locations are dropped, the core expects none
  assign accept = i_req.valid && mapped && (!(is_bit_wr || is_bit_test) || bit_ok);
  assign do_wr  = i_ce && accept && (is_write || is_bit_wr);

  // Byte write hits every lane; a bit op drives one lane only
  always_comb begin
    wmask = 8'hFF;
    wdata = i_req.wdata;
    if (is_bit_wr) begin
      wmask = 8'h01 << i_req.bit_sel;
      wdata = (i_req.op == IORB_OP_SINGLE_BIT_SET) ? 8'hFF : 8'h00;
    end
  end

  // One cell per location; reserved ones have empty masks and fold away
  for (genvar k = 0; k < IORB_NREG; k++) begin : g_cell
    iorb_cell #(
      .RW_MASK  (IORB_RW_MASK[k]),
      .W1C_MASK (IORB_W1C_MASK[k]),
      .HW_MASK  (IORB_HW_MASK[k]),
      .RST_VAL  (IORB_RST_VAL[k])
    ) u_cell (
      .i_clk    (i_clk),
      .i_nrst   (i_nrst),
      .i_ce     (i_ce),
      .i_wr     (do_wr && (io_addr == IORB_IOW'(k))),
      .i_wmask  (wmask),
      .i_wdata  (wdata),
      .i_hw_set (i_hw_set[k]),
      .i_hw_val (i_hw_val[k]),
      .o_q      (o_regs[k]),
      .o_rd     (rd_bank[k])
    );
  end

  // Read value before this access takes effect
  assign rd_sel = mapped ? rd_bank[io_addr[4:0]] : 8'h00;

  // Answer is one cycle after the request, held one cycle
  always_comb begin
    st_nxt          = st_r;
    st_nxt.rsp      = '0;
    if (i_req.valid) begin
      st_nxt.rsp.ack = 1'b1;
      st_nxt.rsp.hit = accept;
      st_nxt.rsp.err = !accept;
      if (accept && (i_req.op == IORB_OP_READ)) begin
        st_nxt.rsp.rdata = rd_sel;
      end
      if (accept && is_bit_test) begin
        st_nxt.rsp.bit_val = rd_sel[i_req.bit_sel];
        st_nxt.rsp.skip    = (i_req.op == IORB_OP_SKIP_IF_BIT_SET) ?
                             rd_sel[i_req.bit_sel] : !rd_sel[i_req.bit_sel];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= '0;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  assign o_rsp = st_r.rsp;

endmodule // iorb_bank

// ===== iorb_bank_monitor.sv
`timescale 1ns/1ns
module iorb_bank_monitor
  import iorb_pkg::*;
(
  input wire logic       i_clk,
  input wire logic       i_nrst,
  input wire logic       i_ce,
  input wire iorb_req_t  i_req,
  input wire iorb_bank_t i_hw_set,
  input wire iorb_bank_t i_hw_val,
  input wire iorb_rsp_t  o_rsp,
  input wire iorb_bank_t o_regs
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  iorb_req_t  q_r;
  iorb_bank_t b_r;
  logic [4:0] x;
  logic       tk;
  logic       bo;
  logic       sk;
  logic       rw;
  // Request and bank as they stood at the taking edge
  always_ff @(posedge i_clk) begin
    q_r <= i_req;
    b_r <= o_regs;
  end
  // Flag pulses excluded so that before and after compare exactly
  assign x  = q_r.addr[4:0];
  assign tk = i_ce && i_req.valid && i_hw_set == '0;
  assign bo = i_req.op inside {IORB_OP_SINGLE_BIT_SET, IORB_OP_SINGLE_BIT_CLEAR};
  assign sk = i_req.op inside {IORB_OP_SKIP_IF_BIT_SET, IORB_OP_SKIP_IF_BIT_CLEAR};
  assign rw = IORB_RW_MASK[i_req.addr[4:0]][i_req.bit_sel];
  sequence s_io;
    tk && !i_req.data_space && i_req.addr <= 8'h18;
  endsequence
  property p_bit_rw;
    s_io ##0 (bo && rw) |=> o_rsp.hit
      && o_regs[x][q_r.bit_sel] == (q_r.op == IORB_OP_SINGLE_BIT_SET);
  endproperty
  property p_bit_only;
    s_io ##0 bo |=> ((o_regs[x] ^ b_r[x]) & ~(8'h01 << q_r.bit_sel)) == 8'h00;
  endproperty
  property p_bit_hi;
    tk && bo && (i_req.data_space || i_req.addr > 8'h1F)
      |=> o_rsp.err && !o_rsp.hit && o_regs == b_r;
  endproperty
  property p_w1c;
    s_io ##0 (i_req.op == IORB_OP_WRITE && i_req.addr == 8'h0B)
      |=> o_regs[11] == (b_r[11] & ~q_r.wdata);
  endproperty
  property p_skip;
    s_io ##0 (sk && rw) |=> o_rsp.ack && o_rsp.bit_val == b_r[x][q_r.bit_sel]
      && o_rsp.skip == (o_rsp.bit_val == (q_r.op == IORB_OP_SKIP_IF_BIT_SET));
  endproperty
  property p_alias;
    tk && i_req.data_space && i_req.op == IORB_OP_READ && rw
      && i_req.addr inside {[8'h20:8'h38]}
      |=> o_rsp.hit && (o_rsp.rdata & IORB_RW_MASK[x]) == (b_r[x] & IORB_RW_MASK[x]);
  endproperty
  a_bit_rw: assert property (p_bit_rw) else $error("bit op result wrong");
  a_skip: assert property (p_skip) else $error("skip answer wrong");
  a_w1c: assert property (p_w1c) else $error("flag clear wrong");
  a_bit_only: assert property (p_bit_only) else $error("other bit changed");
  a_bit_hi: assert property (p_bit_hi) else $error("bit op not refused");
  a_alias: assert property (p_alias) else $error("alias read wrong");
endmodule // iorb_bank_monitor

bind iorb_bank iorb_bank_monitor u_mon (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce),
  .i_req(i_req), .i_hw_set(i_hw_set), .i_hw_val(i_hw_val), .o_rsp(o_rsp), .o_regs(o_regs));

// ===== iorb_cell.sv
`timescale 1ns/1ns
module iorb_cell
  import iorb_pkg::*;
#(
  parameter logic [IORB_DW-1:0] RW_MASK  = 8'hFF,
  parameter logic [IORB_DW-1:0] W1C_MASK = 8'h00,
  parameter logic [IORB_DW-1:0] HW_MASK  = 8'h00,
  parameter logic [IORB_DW-1:0] RST_VAL  = 8'h00
) (
  input  wire logic               i_clk,
  input  wire logic               i_nrst,
  input  wire logic               i_ce,
  input  wire logic               i_wr,
  input  wire logic [IORB_DW-1:0] i_wmask,
  input  wire logic [IORB_DW-1:0] i_wdata,
  input  wire logic [IORB_DW-1:0] i_hw_set,
  input  wire logic [IORB_DW-1:0] i_hw_val,
  output logic      [IORB_DW-1:0] o_q,
  output logic      [IORB_DW-1:0] o_rd
);

  typedef struct packed {
    logic [IORB_DW-1:0] q;
  } iorb_cell_st_t;

  localparam logic [IORB_DW-1:0] KEEP = RW_MASK | W1C_MASK;

  iorb_cell_st_t st_r;
  iorb_cell_st_t st_nxt;
  logic [IORB_DW-1:0] wsel;
  logic [IORB_DW-1:0] clr;

  // Next value: plain bits follow the write, flags clear on one, set wins
  always_comb begin
    st_nxt = st_r;
    wsel   = i_wr ? i_wmask : 8'h00;
    clr    = wsel & i_wdata & W1C_MASK;
    st_nxt.q = (st_r.q & ~(wsel & RW_MASK)) | (i_wdata & wsel & RW_MASK);
    st_nxt.q = ((st_nxt.q & ~clr) | (i_hw_set & W1C_MASK)) & KEEP;
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r.q <= RST_VAL & KEEP;
    end else if (i_ce) begin
      st_r <= st_nxt;
    end
  end

  // Reserved bits read zero; live bits come straight from the peripheral
  assign o_q  = st_r.q;
  assign o_rd = (st_r.q & KEEP) | (i_hw_val & HW_MASK);

endmodule // iorb_cell

// ===== iorb_core_model.sv
`timescale 1ns/1ns
module iorb_core_model
  import iorb_pkg::*;
(
  input  wire logic      i_clk,
  input  wire iorb_rsp_t i_rsp,
  output iorb_req_t      o_req
);
  initial o_req = '0;
  // Entered at a rising edge; the request stands until the taking edge
  task automatic access(input iorb_op_t op, input logic ds, input logic [7:0] a,
                        input logic [2:0] b, input logic [7:0] d, output iorb_rsp_t r);
    logic [7:0] m;
    m = IORB_RW_MASK[a[4:0]] | IORB_W1C_MASK[a[4:0]];
    r = '0;
    if (op != IORB_OP_WRITE || m != 8'h00) begin
      o_req <= '{1'b1, op, ds, a, b, d & m};
      @(posedge i_clk);
      o_req.valid <= 1'b0;
      // Answer stands one cycle only, so take it mid-cycle
      @(negedge i_clk);
      r = i_rsp;
    end
    @(posedge i_clk);
  endtask
endmodule // iorb_core_model

// ===== iorb_pkg.sv
package iorb_pkg;

  // Register map geometry
  localparam int unsigned IORB_DW   = 8;
  localparam int unsigned IORB_NREG = 25;
  localparam int unsigned IORB_IOW  = 6;
  localparam int unsigned IORB_AW   = 8;

  localparam logic [IORB_IOW-1:0] IORB_IO_LAST  = 6'h18;  // Highest implemented address
  localparam logic [IORB_IOW-1:0] IORB_BIT_MAX  = 6'h1F;  // Top of bit-accessible range
  localparam logic [IORB_AW-1:0]  IORB_DS_OFS   = 8'h20;  // Data-space alias offset
  localparam logic [IORB_AW-1:0]  IORB_DS_LAST  = 8'h5F;  // Last data-space alias of I/O
  localparam logic [IORB_AW-1:0]  IORB_IO_TOP   = 8'h3F;  // Last I/O-space address

  // Register offsets
  localparam logic [IORB_IOW-1:0] IORB_POWER_REDUCTION_CONTROL   = 6'h00;
  localparam logic [IORB_IOW-1:0] IORB_DIGITAL_INPUT_DISABLE_0   = 6'h01;
  localparam logic [IORB_IOW-1:0] IORB_CONVERTER_CONTROL_B       = 6'h03;
  localparam logic [IORB_IOW-1:0] IORB_CONVERTER_RESULT_LOW      = 6'h04;
  localparam logic [IORB_IOW-1:0] IORB_CONVERTER_RESULT_HIGH     = 6'h05;
  localparam logic [IORB_IOW-1:0] IORB_CONVERTER_CONTROL_STATUS_A = 6'h06;
  localparam logic [IORB_IOW-1:0] IORB_CONVERTER_CHANNEL_SELECT  = 6'h07;
  localparam logic [IORB_IOW-1:0] IORB_COMPARATOR_CONTROL_STATUS = 6'h08;
  localparam logic [IORB_IOW-1:0] IORB_TIMER1_FLAGS              = 6'h0B;
  localparam logic [IORB_IOW-1:0] IORB_TIMER1_INTERRUPT_MASK     = 6'h0C;
  localparam logic [IORB_IOW-1:0] IORB_SERIAL_IFACE_CONTROL      = 6'h0D;
  localparam logic [IORB_IOW-1:0] IORB_SERIAL_IFACE_STATUS       = 6'h0E;
  localparam logic [IORB_IOW-1:0] IORB_SERIAL_IFACE_SHIFT_DATA   = 6'h0F;
  localparam logic [IORB_IOW-1:0] IORB_SERIAL_IFACE_BUFFER       = 6'h10;
  localparam logic [IORB_IOW-1:0] IORB_PIN_CHANGE_MASK_0         = 6'h12;
  localparam logic [IORB_IOW-1:0] IORB_SCRATCH_REGISTER_0        = 6'h13;
  localparam logic [IORB_IOW-1:0] IORB_SCRATCH_REGISTER_1        = 6'h14;
  localparam logic [IORB_IOW-1:0] IORB_SCRATCH_REGISTER_2        = 6'h15;
  localparam logic [IORB_IOW-1:0] IORB_PORT_B_PIN_LEVELS         = 6'h16;
  localparam logic [IORB_IOW-1:0] IORB_PORT_B_DIRECTION          = 6'h17;
  localparam logic [IORB_IOW-1:0] IORB_PORT_B_OUTPUT_LATCH       = 6'h18;

  typedef logic [IORB_NREG-1:0][IORB_DW-1:0] iorb_bank_t;

  // Bits software may write and read back
  localparam iorb_bank_t IORB_RW_MASK = '{
    0: 8'h0F, 1: 8'hFF, 3: 8'hD7, 6: 8'hEF, 7: 8'hFF, 8: 8'hCF, 12: 8'h27,
    13: 8'hFF, 14: 8'h0F, 15: 8'hFF, 18: 8'hFF, 19: 8'hFF, 20: 8'hFF,
    21: 8'hFF, 23: 8'h0F, 24: 8'h0F, default: 8'h00};
  // Flags set by hardware, cleared by a written one
  localparam iorb_bank_t IORB_W1C_MASK = '{
    6: 8'h10, 8: 8'h10, 11: 8'h27, 14: 8'hE0, default: 8'h00};
  // Bits that show live peripheral state
  localparam iorb_bank_t IORB_HW_MASK = '{
    4: 8'hFF, 5: 8'hFF, 8: 8'h20, 14: 8'h10, 16: 8'hFF, 22: 8'h0F,
    default: 8'h00};
  localparam iorb_bank_t IORB_RST_VAL = '{default: 8'h00};

  // Core access kinds
  typedef enum logic [2:0] {
    IORB_OP_READ      = 3'h0,
    IORB_OP_WRITE     = 3'h1,
    IORB_OP_SINGLE_BIT_SET   = 3'h2,
    IORB_OP_SINGLE_BIT_CLEAR = 3'h3,
    IORB_OP_SKIP_IF_BIT_SET   = 3'h4,
    IORB_OP_SKIP_IF_BIT_CLEAR = 3'h5
  } iorb_op_t;

  typedef struct packed {
    logic              valid;
    iorb_op_t          op;
    logic              data_space;  // Address is a data-space address
    logic [IORB_AW-1:0] addr;
    logic [2:0]        bit_sel;
    logic [IORB_DW-1:0] wdata;
  } iorb_req_t;

  typedef struct packed {
    logic              ack;
    logic              hit;         // Mapped and accepted
    logic              err;         // Reserved target or illegal bit access
    logic [IORB_DW-1:0] rdata;
    logic              bit_val;
    logic              skip;
  } iorb_rsp_t;

endpackage
